//--- src/scc_protocol_timer.sv
// Purpose: per-channel 24-bit protocol timer with AXI4-Lite registers
// Assumes: all inputs synchronous to mclk; count clocks sampled as levels
// Notes: one interrupt status bit per channel, masked onto irq
// Behaviour
// - source 0: count effective transmit clock
// - source 1: count frame sync, mode 5
// - external mode: CPU start command starts timer
// - external expiry without restarts stops, interrupts
// - external: writing zero value stops timer
// - internal mode: protocol engine drives timer
// - internal: count sets poll retries, 7 unlimited
// - external: count sets automatic restarts, max 6
// - external count 7: periodic interrupt forever
// - period is value plus one ticks
`include "scc_timer_map.svh"

module scc_protocol_timer #(
    parameter int NUM_CH = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input scc_timer_pkg::chan_in_t chanIn [NUM_CH],
    output scc_timer_pkg::chan_out_t chanOut [NUM_CH],
    output logic irq
);
    import scc_timer_pkg::*;

    localparam logic [11:0] CH_OFS [4] = '{`TMR_CH0_OFS, `TMR_CH1_OFS,
        `TMR_CH2_OFS, `TMR_CH3_OFS};
    localparam logic [2:0] CNT_INF = `TMR_CNT_UNLIMITED;

    // refuse channel counts with no documented register
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("NUM_CH must be 1 to 4");
    end

    logic awHeldReg, awHeldNext, wHeldReg, wHeldNext;
    logic [11:0] awAddrReg, awAddrNext;
    logic [31:0] wDataReg, wDataNext;
    logic [3:0] wStrbReg, wStrbNext;
    logic bvalidReg, bvalidNext, rvalidReg, rvalidNext;
    logic [1:0] brespReg, brespNext, rrespReg, rrespNext;
    logic [31:0] rdataReg, rdataNext;
    tcfg_t cfgReg [NUM_CH];
    tcfg_t cfgNext [NUM_CH];
    logic [NUM_CH-1:0] statusReg, statusNext, maskReg, maskNext;
    logic [NUM_CH-1:0] zeroWr, expIrq, tick, expire;
    tstate_t stReg [NUM_CH];
    tstate_t stNext [NUM_CH];
    logic [23:0] cntReg [NUM_CH];
    logic [23:0] cntNext [NUM_CH];
    logic [2:0] restReg [NUM_CH];
    logic [2:0] restNext [NUM_CH];
    logic [NUM_CH-1:0] prevReg, prevNext;
    chan_out_t outReg [NUM_CH];
    chan_out_t outNext [NUM_CH];

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] applyStrb(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[8*i+:8] = data[8*i+:8];
        end
        return r;
    endfunction

    // handshake outputs straight from the holding state
    assign s_axi_awready = !awHeldReg;
    assign s_axi_wready = !wHeldReg;
    assign s_axi_arready = !rvalidReg;
    assign s_axi_bvalid = bvalidReg;
    assign s_axi_bresp = brespReg;
    assign s_axi_rvalid = rvalidReg;
    assign s_axi_rdata = rdataReg;
    assign s_axi_rresp = rrespReg;
    assign irq = |(statusReg & maskReg);
    assign chanOut = outReg;

    // register bus: write capture, decode, read
    always_comb
    begin
        logic hit;
        logic [31:0] merged;
        hit = 1'b0;
        merged = 32'h0000_0000;
        awHeldNext = awHeldReg;
        wHeldNext = wHeldReg;
        awAddrNext = awAddrReg;
        wDataNext = wDataReg;
        wStrbNext = wStrbReg;
        bvalidNext = bvalidReg;
        brespNext = brespReg;
        rvalidNext = rvalidReg;
        rdataNext = rdataReg;
        rrespNext = rrespReg;
        cfgNext = cfgReg;
        maskNext = maskReg;
        zeroWr = '0;
        // a new event wins over a clear in the same cycle
        statusNext = statusReg | expIrq;
        if (s_axi_awvalid && !awHeldReg)
        begin
            awHeldNext = 1'b1;
            awAddrNext = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeldReg)
        begin
            wHeldNext = 1'b1;
            wDataNext = s_axi_wdata;
            wStrbNext = s_axi_wstrb;
        end
        if (bvalidReg && s_axi_bready)
            bvalidNext = 1'b0;
        if (awHeldReg && wHeldReg && !bvalidReg)
        begin
            awHeldNext = 1'b0;
            wHeldNext = 1'b0;
            bvalidNext = 1'b1;
            brespNext = `AXI_RESP_OKAY;
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (awAddrReg == CH_OFS[c])
                begin
                    hit = 1'b1;
                    merged = applyStrb(cfgReg[c], wDataReg, wStrbReg) & `TMR_WR_MASK;
                    cfgNext[c] = tcfg_t'(merged);
                    zeroWr[c] = (merged[`TMR_VALUE_MSB:0] == 24'h00_0000);
                end
            end
            if (hit)
                brespNext = `AXI_RESP_OKAY;
            else if (awAddrReg == `TMR_IRQ_STATUS_OFS && wStrbReg[0])
                statusNext = (statusReg & ~wDataReg[NUM_CH-1:0]) | expIrq;
            else if (awAddrReg == `TMR_IRQ_MASK_OFS && wStrbReg[0])
                maskNext = wDataReg[NUM_CH-1:0];
            else if (awAddrReg != `TMR_IRQ_STATUS_OFS && awAddrReg != `TMR_IRQ_MASK_OFS)
                brespNext = `AXI_RESP_SLVERR;
        end
        if (rvalidReg && s_axi_rready)
            rvalidNext = 1'b0;
        if (s_axi_arvalid && !rvalidReg)
        begin
            rvalidNext = 1'b1;
            rrespNext = `AXI_RESP_SLVERR;
            rdataNext = 32'h0000_0000;
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (s_axi_araddr == CH_OFS[c])
                begin
                    rrespNext = `AXI_RESP_OKAY;
                    rdataNext = cfgReg[c];
                end
            end
            if (s_axi_araddr == `TMR_IRQ_STATUS_OFS)
            begin
                rrespNext = `AXI_RESP_OKAY;
                rdataNext = 32'(statusReg);
            end
            else if (s_axi_araddr == `TMR_IRQ_MASK_OFS)
            begin
                rrespNext = `AXI_RESP_OKAY;
                rdataNext = 32'(maskReg);
            end
        end
    end

    // register bus state
    // zero after reset
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awHeldReg <= 1'b0;
            wHeldReg <= 1'b0;
            awAddrReg <= 12'h000;
            wDataReg <= 32'h0000_0000;
            wStrbReg <= 4'h0;
            bvalidReg <= 1'b0;
            brespReg <= `AXI_RESP_OKAY;
            rvalidReg <= 1'b0;
            rdataReg <= 32'h0000_0000;
            rrespReg <= `AXI_RESP_OKAY;
            for (int c = 0; c < NUM_CH; c++)
                cfgReg[c] <= tcfg_t'(`TMR_CFG_RESET);
            statusReg <= '0;
            maskReg <= '0;
        end
        else
        begin
            awHeldReg <= awHeldNext;
            wHeldReg <= wHeldNext;
            awAddrReg <= awAddrNext;
            wDataReg <= wDataNext;
            wStrbReg <= wStrbNext;
            bvalidReg <= bvalidNext;
            brespReg <= brespNext;
            rvalidReg <= rvalidNext;
            rdataReg <= rdataNext;
            rrespReg <= rrespNext;
            cfgReg <= cfgNext;
            statusReg <= statusNext;
            maskReg <= maskNext;
        end
    end

    // timers: tick select, start, stop, expiry
    always_comb
    begin
        logic sel, start, stop;
        sel = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        stNext = stReg;
        cntNext = cntReg;
        restNext = restReg;
        expIrq = '0;
        tick = '0;
        expire = '0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            outNext[c] = '0;
            sel = cfgReg[c].src ? (chanIn[c].frameSync && chanIn[c].clockMode5)
                                : chanIn[c].txClk;
            prevNext[c] = sel;
            tick[c] = sel && !prevReg[c];
            start = cfgReg[c].timer_mode_select ? (chanIn[c].automode && chanIn[c].protoStart)
                                  : chanIn[c].startCmd;
            stop = cfgReg[c].timer_mode_select ? chanIn[c].protoStop : zeroWr[c];
            case (stReg[c])
                T_IDLE:
                begin
                    if (start && !stop)
                    begin
                        stNext[c] = T_RUN;
                        cntNext[c] = cfgReg[c].value;
                        restNext[c] = cfgReg[c].cnt;
                    end
                end
                T_RUN:
                begin
                    if (stop)
                        stNext[c] = T_IDLE;
                    else if (start)
                    begin
                        cntNext[c] = cfgReg[c].value;
                        restNext[c] = cfgReg[c].cnt;
                    end
                    else if (tick[c] && cntReg[c] != 24'h00_0000)
                        cntNext[c] = cntReg[c] - 24'h00_0001;
                    else if (tick[c])
                    begin
                        expire[c] = 1'b1;
                        cntNext[c] = cfgReg[c].value;
                        if (restReg[c] != CNT_INF && restReg[c] != 3'h0)
                            restNext[c] = restReg[c] - 3'h1;
                        if (cfgReg[c].timer_mode_select)
                        begin
                            outNext[c].timeout = 1'b1;
                            if (restReg[c] != 3'h0)
                                outNext[c].pollReq = 1'b1;
                            else
                            begin
                                outNext[c].exhausted = 1'b1;
                                stNext[c] = T_IDLE;
                            end
                        end
                        else if (restReg[c] == CNT_INF)
                            expIrq[c] = 1'b1;
                        else if (restReg[c] == 3'h0)
                        begin
                            expIrq[c] = 1'b1;
                            stNext[c] = T_IDLE;
                        end
                    end
                end
                default: stNext[c] = T_IDLE;
            endcase
            outNext[c].running = (stNext[c] == T_RUN);
        end
    end

    // timer state
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                stReg[c] <= T_IDLE;
                cntReg[c] <= 24'h00_0000;
                restReg[c] <= 3'h0;
                outReg[c] <= '0;
            end
            prevReg <= '0;
        end
        else
        begin
            stReg <= stNext;
            cntReg <= cntNext;
            restReg <= restNext;
            outReg <= outNext;
            prevReg <= prevNext;
        end
    end

    // checks on channel 0
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_tx_tick;
        !cfgReg[0].src && !chanIn[0].txClk ##1 chanIn[0].txClk |-> tick[0];
    endproperty
    a_tx_tick: assert property (p_tx_tick) else $error("missed transmit tick");
    property p_fs_gate;
        cfgReg[0].src && !chanIn[0].clockMode5 |-> !tick[0];
    endproperty
    a_fs_gate: assert property (p_fs_gate) else $error("frame sync outside mode 5");
    property p_start;
        stReg[0] == T_IDLE && !cfgReg[0].timer_mode_select && chanIn[0].startCmd && !zeroWr[0]
            |=> stReg[0] == T_RUN && cntReg[0] == $past(cfgReg[0].value);
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_final;
        expire[0] && !cfgReg[0].timer_mode_select && restReg[0] == 3'h0
            |=> stReg[0] == T_IDLE && statusReg[0];
    endproperty
    a_final: assert property (p_final) else $error("expiry did not stop");
    property p_zero;
        stReg[0] == T_RUN && !cfgReg[0].timer_mode_select && zeroWr[0] |=> stReg[0] == T_IDLE;
    endproperty
    a_zero: assert property (p_zero) else $error("zero write did not stop");
    property p_internal;
        stReg[0] == T_IDLE && cfgReg[0].timer_mode_select && !chanIn[0].protoStart |=> stReg[0] == T_IDLE;
    endproperty
    a_internal: assert property (p_internal) else $error("cpu started internal timer");
    property p_poll;
        expire[0] && cfgReg[0].timer_mode_select && restReg[0] != 3'h0
            |=> outReg[0].pollReq && stReg[0] == T_RUN;
    endproperty
    a_poll: assert property (p_poll) else $error("poll retry missing");
    property p_restart;
        expire[0] && !cfgReg[0].timer_mode_select && restReg[0] != 3'h0 && restReg[0] != CNT_INF
            |=> stReg[0] == T_RUN && restReg[0] == $past(restReg[0]) - 3'h1
                && cntReg[0] == $past(cfgReg[0].value);
    endproperty
    a_restart: assert property (p_restart) else $error("restart not reloaded");
    property p_periodic;
        expire[0] && !cfgReg[0].timer_mode_select && restReg[0] == CNT_INF
            |=> stReg[0] == T_RUN && statusReg[0] && restReg[0] == CNT_INF;
    endproperty
    a_periodic: assert property (p_periodic) else $error("periodic mode stopped");
    property p_expire_at_zero;
        expire[0] |-> cntReg[0] == 24'h00_0000 && tick[0];
    endproperty
    a_expire_at_zero: assert property (p_expire_at_zero) else $error("early expiry");

    c_final: cover property (expire[0] && !cfgReg[0].timer_mode_select ##1 stReg[0] == T_IDLE);
    c_periodic: cover property (expire[0] && restReg[0] == CNT_INF);
    c_poll: cover property (outReg[0].pollReq);
    c_irq: cover property (irq);

endmodule // scc_protocol_timer

//--- src/scc_timer_map.svh
// Purpose: offsets, field positions and reset values of the protocol timer
// Assumes: byte addresses on a 12-bit AXI4-Lite window
// Notes: definitions only
`ifndef SCC_TIMER_MAP_SVH
`define SCC_TIMER_MAP_SVH

// timer configuration registers, one per channel
`define TMR_CH0_OFS 12'h130
`define TMR_CH1_OFS 12'h1B0
`define TMR_CH2_OFS 12'h230
`define TMR_CH3_OFS 12'h2B0
// interrupt status (write one to clear) and mask
`define TMR_IRQ_STATUS_OFS 12'h300
`define TMR_IRQ_MASK_OFS 12'h304
// field positions
`define TMR_SRC_BIT 31
`define TMR_TMD_BIT 28
`define TMR_CNT_LSB 24
`define TMR_VALUE_MSB 23
// reset values and writable bits
`define TMR_CFG_RESET 32'h0000_0000
`define TMR_WR_MASK 32'h97FF_FFFF
`define TMR_CNT_UNLIMITED 3'h7
// bus answers
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

//--- src/scc_timer_pkg.sv
// Purpose: types shared by the protocol timer
// Assumes: field layout of the timer configuration register
// Notes: widths follow the map header
package scc_timer_pkg;

    // timer configuration word
    typedef struct packed {
        logic src;
        logic [1:0] rsvdHi;
        logic timer_mode_select;
        logic rsvdLo;
        logic [2:0] cnt;
        logic [23:0] value;
    } tcfg_t;

    // per-channel timer state
    typedef enum logic [1:0] {
        T_IDLE = 2'b01,
        T_RUN = 2'b10
    } tstate_t;

    // per-channel inputs from the serial channel and protocol engine
    typedef struct packed {
        logic txClk;
        logic frameSync;
        logic clockMode5;
        logic automode;
        logic startCmd;
        logic protoStart;
        logic protoStop;
    } chan_in_t;

    // per-channel outputs to the protocol engine
    typedef struct packed {
        logic timeout;
        logic pollReq;
        logic exhausted;
        logic running;
    } chan_out_t;

endpackage

//--- tb/scc_protocol_timer_tb.sv
// Purpose: self-checking bench for the per-channel protocol timer
// Assumes: one clock, registers over AXI4-Lite, count clocks driven as levels
// Notes: protocol engine pulses of channel 0 are counted by a monitor
`include "scc_timer_map.svh"

`define CHK(got, exp) \
    begin \
        checksDone++; \
        if ((got) !== (exp)) \
        begin \
            errCount++; \
            $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); \
        end \
    end

module scc_protocol_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scc_timer_pkg::*;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    chan_in_t chanIn [4];
    chan_out_t chanOut [4];
    int errCount = 0, checksDone = 0, pollSeen = 0, exhSeen = 0, toSeen = 0;

    // free-running 250 MHz clock
    always #2 mclk = ~mclk;

    scc_protocol_timer #(.NUM_CH(4)) u_scc_protocol_timer (
        .mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .chanIn(chanIn), .chanOut(chanOut), .irq(irq)
    );

    // count one-cycle pulses towards the protocol engine
    always @(posedge mclk)
    begin
        if (chanOut[0].pollReq === 1'b1) pollSeen <= pollSeen + 1;
        if (chanOut[0].exhausted === 1'b1) exhSeen <= exhSeen + 1;
        if (chanOut[0].timeout === 1'b1) toSeen <= toSeen + 1;
    end

    function automatic logic [11:0] cfgAddr(input int c);
        return 12'h130 + 12'h080 * c[11:0];
    endfunction

    function automatic logic [31:0] cfg(logic s, logic m, logic [2:0] n, logic [23:0] v);
        return {s, 2'b00, m, 1'b0, n, v};
    endfunction

    task axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        // a write answer that never came counts as a mismatch
        if (n >= 40) errCount++;
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task chkReg(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        // a read answer that never came counts as a mismatch
        if (n >= 40) errCount++;
        rd = s_axi_rdata;
        `CHK(rd, e)
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask

    task chkStatus(input logic [31:0] e);
        chkReg(`TMR_IRQ_STATUS_OFS, e, `AXI_RESP_OKAY);
    endtask

    task pulseStart(input int c, input logic proto);
        if (proto) chanIn[c].protoStart <= 1'b1;
        else chanIn[c].startCmd <= 1'b1;
        @(posedge mclk);
        chanIn[c].protoStart <= 1'b0;
        chanIn[c].startCmd <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    // n rising edges of the transmit clock or of frame sync
    task ticks(input int c, input int n, input logic fs);
        repeat (n)
        begin
            if (fs) chanIn[c].frameSync <= 1'b1;
            else chanIn[c].txClk <= 1'b1;
            repeat (2) @(posedge mclk);
            chanIn[c].frameSync <= 1'b0;
            chanIn[c].txClk <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        repeat (3) @(posedge mclk);
    endtask

    task testReset;
        for (int c = 0; c < 4; c++) chkReg(cfgAddr(c), 32'h0, `AXI_RESP_OKAY);
        chkStatus(32'h0);
        `CHK(chanOut[1].running, 1'b0)
        chkReg(12'h100, 32'h0, `AXI_RESP_SLVERR);
        axiWrite(12'h100, 32'hFFFF_FFFF, `AXI_RESP_SLVERR);
        axiWrite(cfgAddr(1), 32'hFFFF_FFFF, `AXI_RESP_OKAY);
        chkReg(cfgAddr(1), 32'h97FF_FFFF, `AXI_RESP_OKAY);
        axiWrite(cfgAddr(1), 32'h0, `AXI_RESP_OKAY);
    endtask

    task testOneShot;
        axiWrite(`TMR_IRQ_MASK_OFS, 32'hF, `AXI_RESP_OKAY);
        axiWrite(cfgAddr(1), cfg(1'b0, 1'b0, 3'h0, 24'h3), `AXI_RESP_OKAY);
        pulseStart(1, 1'b0);
        `CHK(chanOut[1].running, 1'b1)
        ticks(1, 3, 1'b0);
        chkStatus(32'h0);
        ticks(1, 1, 1'b0);
        chkStatus(32'h2);
        `CHK(chanOut[1].running, 1'b0)
        `CHK(irq, 1'b1)
        axiWrite(`TMR_IRQ_MASK_OFS, 32'h0, `AXI_RESP_OKAY);
        `CHK(irq, 1'b0)
        axiWrite(`TMR_IRQ_MASK_OFS, 32'hF, `AXI_RESP_OKAY);
        axiWrite(`TMR_IRQ_STATUS_OFS, 32'h2, `AXI_RESP_OKAY);
        `CHK(irq, 1'b0)
    endtask

    task testRestart;
        axiWrite(cfgAddr(1), cfg(1'b0, 1'b0, 3'h2, 24'h1), `AXI_RESP_OKAY);
        pulseStart(1, 1'b0);
        ticks(1, 5, 1'b0);
        chkStatus(32'h0);
        `CHK(chanOut[1].running, 1'b1)
        ticks(1, 1, 1'b0);
        chkStatus(32'h2);
        `CHK(chanOut[1].running, 1'b0)
        axiWrite(`TMR_IRQ_STATUS_OFS, 32'h2, `AXI_RESP_OKAY);
    endtask

    task testPeriodic;
        axiWrite(cfgAddr(2), cfg(1'b0, 1'b0, 3'h7, 24'h1), `AXI_RESP_OKAY);
        pulseStart(2, 1'b0);
        ticks(2, 2, 1'b0);
        chkStatus(32'h4);
        axiWrite(`TMR_IRQ_STATUS_OFS, 32'h4, `AXI_RESP_OKAY);
        ticks(2, 2, 1'b0);
        chkStatus(32'h4);
        `CHK(chanOut[2].running, 1'b1)
        axiWrite(cfgAddr(2), cfg(1'b0, 1'b0, 3'h7, 24'h0), `AXI_RESP_OKAY);
        `CHK(chanOut[2].running, 1'b0)
        axiWrite(`TMR_IRQ_STATUS_OFS, 32'h4, `AXI_RESP_OKAY);
    endtask

    task testFrameSync;
        axiWrite(cfgAddr(3), cfg(1'b1, 1'b0, 3'h0, 24'h0), `AXI_RESP_OKAY);
        pulseStart(3, 1'b0);
        ticks(3, 1, 1'b1);
        ticks(3, 1, 1'b0);
        chkStatus(32'h0);
        chanIn[3].clockMode5 <= 1'b1;
        ticks(3, 1, 1'b1);
        chkStatus(32'h8);
        axiWrite(`TMR_IRQ_STATUS_OFS, 32'h8, `AXI_RESP_OKAY);
    endtask

    task testInternal;
        chanIn[0].automode <= 1'b1;
        axiWrite(cfgAddr(0), cfg(1'b0, 1'b1, 3'h1, 24'h0), `AXI_RESP_OKAY);
        pulseStart(0, 1'b0);
        `CHK(chanOut[0].running, 1'b0)
        pulseStart(0, 1'b1);
        `CHK(chanOut[0].running, 1'b1)
        ticks(0, 1, 1'b0);
        `CHK(pollSeen, 1)
        ticks(0, 1, 1'b0);
        `CHK(exhSeen, 1)
        `CHK(toSeen, 2)
        `CHK(chanOut[0].running, 1'b0)
        axiWrite(cfgAddr(0), cfg(1'b0, 1'b1, 3'h7, 24'h0), `AXI_RESP_OKAY);
        pulseStart(0, 1'b1);
        ticks(0, 3, 1'b0);
        `CHK(pollSeen, 4)
        `CHK(exhSeen, 1)
        chkStatus(32'h0);
        // protocol engine stop ends an unlimited retry run
        chanIn[0].protoStop <= 1'b1;
        @(posedge mclk);
        chanIn[0].protoStop <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(chanOut[0].running, 1'b0)
    endtask

    task print_verdict;
        $display("mismatches %0d, comparisons %0d", errCount, checksDone);
        if (errCount == 0 && checksDone > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        for (int c = 0; c < 4; c++) chanIn[c] = '0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        testReset();
        testOneShot();
        testRestart();
        testPeriodic();
        testFrameSync();
        testInternal();
        print_verdict();
    end

    // watchdog against a hung handshake
    initial
    begin
        #40000;
        errCount++;
        print_verdict();
    end
endmodule // scc_protocol_timer_tb
